// >>> asff_formatter.sv
// Serial frame formatter of a four-channel converter with APB registers
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module asff_formatter
    import asff_pkg::*;
(
    input wire logic i_clock, // 40 MHz system clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_sclk, // Serial clock from host
    input wire logic i_cs_n, // Chip select, active low
    input wire logic i_din, // Serial data in
    output logic o_dout, // Serial data out
    output logic o_dout_oe_n, // Data out enable, low while driving
    input wire logic i_word_length_strap_hi, // Strap sensed high
    input wire logic i_word_length_strap_lo, // Strap sensed low
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB direction
    input wire logic [7:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error on unmapped address
    output logic o_irq // Interrupt, active high level
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic asff_wl_t strap_decode(input logic hi, input logic lo);
        if (hi && !lo) begin
            return WL_CODE_32;
        end else if (lo && !hi) begin
            return WL_CODE_24;
        end
        return WL_CODE_16;
    endfunction

    function automatic logic [5:0] wl_bits(input asff_wl_t code);
        case (code)
            WL_CODE_32: return WL_BITS_32;
            WL_CODE_24: return WL_BITS_24;
            default: return WL_BITS_16;
        endcase
    endfunction

    function automatic logic [2:0] word_count(input logic fixed, input logic crc,
                                              input logic power);
        if (fixed || (power && crc)) begin
            return WORDS_FULL;
        end else if (power) begin
            return WORDS_DROP_CRC;
        end else if (crc) begin
            return WORDS_STBY_CRC;
        end
        return WORDS_STBY;
    endfunction

    function automatic logic [15:0] top16(input logic [31:0] rx, input asff_wl_t code);
        case (code)
            WL_CODE_32: return rx[31:16];
            WL_CODE_24: return rx[23:8];
            default: return rx[15:0];
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation and edges
    // ------------------------------------------------------------
    logic sclk_s, cs_n_s, din_s, hi_s, lo_s;
    logic sclk_d, cs_n_d;

    asff_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_async({i_sclk, i_cs_n, i_din, i_word_length_strap_hi, i_word_length_strap_lo}),
        .o_sync({sclk_s, cs_n_s, din_s, hi_s, lo_s})
    );

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign cs_fall = !cs_n_s && cs_n_d;
    assign cs_rise = cs_n_s && !cs_n_d;

    // ------------------------------------------------------------
    // Word-length strap capture
    // ------------------------------------------------------------
    logic [1:0] settle;
    logic strap_taken;
    asff_wl_t wl_code;
    logic [5:0] wl;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            settle <= '0;
            strap_taken <= 1'b0;
            wl_code <= WL_CODE_16;
        end else if (!strap_taken) begin
            if (settle == SETTLE_DONE) begin
                strap_taken <= 1'b1;
                wl_code <= strap_decode(hi_s, lo_s);
            end else begin
                settle <= settle + 2'd1;
            end
        end
    end
    assign wl = wl_bits(wl_code);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic cfg_fixed, cfg_crc, cfg_power;
    logic [IRQ_WIDTH-1:0] irq_status, irq_mask, irq_event;
    logic [15:0] monitor, response, command, rx_check, tx_check;
    logic resp_pending;
    logic [23:0] chan [NUM_CH];
    logic [15:0] status16;
    logic wr_en, setup;
    logic [31:0] rd_data;
    logic rd_hit;
    asff_state_t state;
    logic [2:0] word_idx, frame_words, done_idx;
    logic [5:0] bit_cnt;
    logic [31:0] rx_shift, tx_shift, next_slot;
    logic frame_crc, frame_power, load_pending, word_done;
    logic frame_start;
    logic [15:0] cmd_word;

    assign setup = i_psel && !i_penable;
    assign wr_en = i_psel && i_penable && i_pwrite && rd_hit;
    assign status16 = resp_pending ? response : monitor;
    assign frame_start = (state == ST_IDLE) && cs_fall && strap_taken;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_fixed <= CFG_FIXED_RST;
            cfg_crc <= CFG_CRC_RST;
            cfg_power <= CFG_POWER_RST;
            irq_mask <= '0;
            monitor <= '0;
            response <= '0;
            tx_check <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                chan[i] <= '0;
            end
        end else if (wr_en) begin
            case (i_paddr)
                REG_CONFIG: begin
                    cfg_fixed <= i_pwdata[CFG_FIXED_BIT];
                    cfg_crc <= i_pwdata[CFG_CRC_BIT];
                    cfg_power <= i_pwdata[CFG_POWER_BIT];
                end
                REG_IRQ_MASK: irq_mask <= i_pwdata[IRQ_WIDTH-1:0];
                REG_MONITOR: monitor <= i_pwdata[15:0];
                REG_RESPONSE: response <= i_pwdata[15:0];
                REG_TX_CHECK: tx_check <= i_pwdata[15:0];
                default: begin
                    if (i_paddr >= REG_CHAN_BASE) begin
                        chan[2'((i_paddr - REG_CHAN_BASE) >> 2)] <= i_pwdata[23:0];
                    end
                end
            endcase
        end
    end

    // Response waits for the next frame; a new write wins over the clear
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            resp_pending <= 1'b0;
        end else if (wr_en && i_paddr == REG_RESPONSE) begin
            resp_pending <= 1'b1;
        end else if (frame_start) begin
            resp_pending <= 1'b0;
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status <= '0;
        end else if (wr_en && i_paddr == REG_IRQ_STATUS) begin
            irq_status <= (irq_status & ~i_pwdata[IRQ_WIDTH-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end
    assign o_irq = |(irq_status & irq_mask);

    always_comb begin
        rd_data = '0;
        rd_hit = 1'b1;
        case (i_paddr)
            REG_CONFIG: rd_data = {29'h0, cfg_power, cfg_crc, cfg_fixed};
            REG_IRQ_STATUS: rd_data = {29'h0, irq_status};
            REG_IRQ_MASK: rd_data = {29'h0, irq_mask};
            REG_MONITOR: rd_data = {16'h0, monitor};
            REG_RESPONSE: rd_data = {15'h0, resp_pending, response};
            REG_COMMAND: rd_data = {16'h0, command};
            REG_RX_CHECK: rd_data = {16'h0, rx_check};
            REG_TX_CHECK: rd_data = {16'h0, tx_check};
            REG_INFO: rd_data = {24'h0, strap_taken, (state == ST_SHIFT), wl};
            default: begin
                if (i_paddr >= REG_CHAN_BASE && i_paddr <= REG_CHAN_LAST &&
                    i_paddr[1:0] == 2'b00) begin
                    rd_data = {8'h0, chan[2'((i_paddr - REG_CHAN_BASE) >> 2)]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Read data and error are registered in the setup phase
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata <= i_pwrite ? 32'h0 : rd_data;
            o_pslverr <= !rd_hit;
        end
    end
    assign o_pready = 1'b1;

    // ------------------------------------------------------------
    // Output slot contents
    // ------------------------------------------------------------
    always_comb begin
        next_slot = '0;
        if (word_idx == 3'd0) begin
            next_slot = {status16, 16'h0};
        end else if (word_idx >= frame_words) begin
            next_slot = '0;
        end else if (frame_crc && word_idx == frame_words - 3'd1) begin
            next_slot = {tx_check, 16'h0};
        end else if (frame_power && word_idx <= 3'(NUM_CH)) begin
            next_slot = {chan[2'(word_idx - 3'd1)], 8'h0};
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
            word_idx <= '0;
            bit_cnt <= '0;
            rx_shift <= '0;
            tx_shift <= '0;
            frame_words <= WORDS_STBY;
            frame_crc <= 1'b0;
            frame_power <= 1'b0;
            load_pending <= 1'b0;
            word_done <= 1'b0;
            done_idx <= '0;
        end else begin
            word_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (frame_start) begin
                        state <= ST_SHIFT;
                        bit_cnt <= '0;
                        frame_words <= word_count(cfg_fixed, cfg_crc,
                                                  cfg_power);
                        frame_crc <= cfg_crc;
                        frame_power <= cfg_power;
                        tx_shift <= next_slot;
                        load_pending <= 1'b0;
                    end
                end
                ST_SHIFT: begin
                    if (cs_rise) begin
                        state <= ST_IDLE;
                        word_idx <= '0;
                        tx_shift <= '0;
                    end else begin
                        if (sclk_rise) begin
                            rx_shift <= {rx_shift[30:0], din_s};
                            if (bit_cnt == wl - 6'd1) begin
                                bit_cnt <= '0;
                                word_done <= 1'b1;
                                done_idx <= word_idx;
                                load_pending <= 1'b1;
                                if (word_idx != WORD_IDX_MAX) begin
                                    word_idx <= word_idx + 3'd1;
                                end
                            end else begin
                                bit_cnt <= bit_cnt + 6'd1;
                            end
                        end
                        if (sclk_fall) begin
                            if (load_pending) begin
                                tx_shift <= next_slot;
                                load_pending <= 1'b0;
                            end else begin
                                tx_shift <= {tx_shift[30:0], 1'b0};
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    assign o_dout = tx_shift[31];
    assign o_dout_oe_n = (state != ST_SHIFT);

    // ------------------------------------------------------------
    // Input word capture and events
    // ------------------------------------------------------------
    assign cmd_word = top16(rx_shift, wl_code);

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            command <= '0;
            rx_check <= '0;
        end else if (word_done) begin
            if (done_idx == 3'd0) begin
                command <= cmd_word;
            end
            if (frame_crc && done_idx == frame_words - 3'd1) begin
                rx_check <= cmd_word;
            end
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[IRQ_FRAME_BIT] = (state == ST_SHIFT) && cs_rise;
        irq_event[IRQ_CMD_BIT] = word_done && (done_idx == 3'd0);
        irq_event[IRQ_CHECK_BIT] = word_done && frame_crc && (done_idx == frame_words - 3'd1);
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    logic slot_load;
    assign slot_load = (state == ST_SHIFT) && !cs_rise && sclk_fall && load_pending;

    chk_frame_open: assert property (frame_start |=>
        (state == ST_SHIFT && word_idx == 3'd0 && bit_cnt == 6'd0))
        else $error("frame did not open on chip select fall");
    chk_full_duplex: assert property (((state == ST_SHIFT) && sclk_rise && !cs_rise)
        |=> rx_shift[0] == $past(din_s))
        else $error("input bit not taken during frame");
    chk_strap_hold: assert property (strap_taken |=>
        (strap_taken && $stable(wl_code)))
        else $error("word length changed after capture");
    chk_strap_decode: assert property ((!strap_taken && settle == SETTLE_DONE) |=>
        wl_code == strap_decode($past(hi_s), $past(lo_s)))
        else $error("strap decoded wrongly");
    chk_dynamic_default: assert property ((!strap_taken && settle == 2'd0) |->
        !cfg_fixed)
        else $error("fixed mode set after reset");
    chk_fixed_six: assert property ((frame_start && cfg_fixed) |=>
        frame_words == WORDS_FULL)
        else $error("fixed frame not six words");
    chk_standby_count: assert property ((frame_start && !cfg_fixed &&
        !cfg_power) |=> frame_words == ($past(cfg_crc) ? WORDS_STBY_CRC : WORDS_STBY))
        else $error("standby dynamic word count wrong");
    chk_power_count: assert property ((frame_start && !cfg_fixed &&
        cfg_power) |=> frame_words == ($past(cfg_crc) ? WORDS_FULL : WORDS_DROP_CRC))
        else $error("powered dynamic word count wrong");
    chk_cmd_slot: assert property ((word_done && done_idx == 3'd0) |=>
        command == $past(cmd_word))
        else $error("command not captured from first word");
    chk_status_first: assert property (frame_start |=>
        (tx_shift[31:16] == $past(status16) && tx_shift[15:0] == 16'h0))
        else $error("status word not first or low bits not zero");
    chk_check_slot: assert property (slot_load && frame_crc &&
        word_idx == frame_words - 3'd1 |=> tx_shift == {$past(tx_check), 16'h0})
        else $error("check value not in final word");
    chk_chan_extend: assert property (slot_load && frame_power &&
        word_idx != 3'd0 && word_idx < frame_words &&
        !(frame_crc && word_idx == frame_words - 3'd1) |=> tx_shift[7:0] == 8'h0)
        else $error("channel word low byte not zero");
    chk_pad_zero: assert property (slot_load && word_idx >= frame_words |=>
        tx_shift == 32'h0)
        else $error("unused slot not zero");

    cov_fixed_frame: cover property ((state == ST_SHIFT) && cs_rise &&
        frame_words == WORDS_FULL && !frame_crc);
    cov_command: cover property (word_done && done_idx == 3'd0);
    cov_check_word: cover property (irq_event[IRQ_CHECK_BIT]);
endmodule

// >>> asff_host.sv
// Host controller model driving frames on the serial port
`timescale 1ns/1ps
module asff_host (
    input wire logic i_clock, // System clock
    input wire logic i_dout, // Device serial out
    output logic o_sclk, // Serial clock, still outside frames
    output logic o_cs_n, // Chip select, active low
    output logic o_din // Serial data to device
);
    logic [31:0] rx [8];
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b1;
    end
    // Words right aligned in rx; host samples on sclk rise
    task automatic frame(input int wl, input int nw, input int last, input logic [15:0] cmd,
                         input logic [15:0] chk);
        logic [31:0] tx;
        @(posedge i_clock);
        o_cs_n <= 1'b0;
        repeat (8) @(posedge i_clock);
        for (int w = 0; w < nw; w++) begin
            tx = (w == 0) ? 32'(cmd) << (wl - 16) : '0;
            if (w == last) tx = 32'(chk) << (wl - 16);
            rx[w] = '0;
            for (int b = wl - 1; b >= 0; b--) begin
                o_din <= tx[b];
                repeat (4) @(posedge i_clock);
                o_sclk <= 1'b1;
                rx[w] = {rx[w][30:0], i_dout};
                repeat (4) @(posedge i_clock);
                o_sclk <= 1'b0;
            end
        end
        repeat (4) @(posedge i_clock);
        o_cs_n <= 1'b1;
        o_din <= ~o_din;
        repeat (10) @(posedge i_clock);
    endtask
endmodule

// >>> asff_pkg.sv
// Constants, register map and types for the ADC serial frame formatter
package asff_pkg;
    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH = 4;
    localparam logic [2:0] WORDS_FULL = 3'd6;
    localparam logic [2:0] WORDS_DROP_CRC = 3'd5;
    localparam logic [2:0] WORDS_STBY_CRC = 3'd2;
    localparam logic [2:0] WORDS_STBY = 3'd1;
    localparam logic [2:0] WORD_IDX_MAX = 3'd7;
    localparam logic [5:0] WL_BITS_16 = 6'd16;
    localparam logic [5:0] WL_BITS_24 = 6'd24;
    localparam logic [5:0] WL_BITS_32 = 6'd32;
    localparam int unsigned SYNC_WIDTH = 5;
    localparam logic [1:0] SETTLE_DONE = 2'd3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_MONITOR = 8'h0c;
    localparam logic [7:0] REG_RESPONSE = 8'h10;
    localparam logic [7:0] REG_COMMAND = 8'h14;
    localparam logic [7:0] REG_RX_CHECK = 8'h18;
    localparam logic [7:0] REG_TX_CHECK = 8'h1c;
    localparam logic [7:0] REG_INFO = 8'h20;
    localparam logic [7:0] REG_CHAN_BASE = 8'h24;
    localparam logic [7:0] REG_CHAN_LAST = 8'h30;

    // Field positions
    localparam int unsigned CFG_FIXED_BIT = 0;
    localparam int unsigned CFG_CRC_BIT = 1;
    localparam int unsigned CFG_POWER_BIT = 2;
    localparam int unsigned IRQ_FRAME_BIT = 0;
    localparam int unsigned IRQ_CMD_BIT = 1;
    localparam int unsigned IRQ_CHECK_BIT = 2;
    localparam int unsigned IRQ_WIDTH = 3;

    // Reset values
    localparam logic CFG_FIXED_RST = 1'b0;
    localparam logic CFG_CRC_RST = 1'b0;
    localparam logic CFG_POWER_RST = 1'b0;

    typedef enum logic [1:0] {
        WL_CODE_16,
        WL_CODE_24,
        WL_CODE_32
    } asff_wl_t;

    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } asff_state_t;
endpackage

// >>> asff_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module asff_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic i_clock, // System clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic [WIDTH-1:0] i_async, // Asynchronous inputs
    output logic [WIDTH-1:0] o_sync // Synchronised outputs
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// >>> tb_top.sv
// Testbench for the serial frame formatter
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import asff_pkg::*;
    logic i_clock, i_arst_n, sclk, cs_n, din, dout, oe_n, st_hi, st_lo;
    logic psel, penable, pwrite, pready, pslverr, irq, err, fx, cr, pw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ex;
    logic [15:0] mon;
    logic [2:0] cfg [6] = '{3'b101, 3'b111, 3'b010, 3'b100, 3'b110, 3'b011};
    int mismatches = 0;
    int checked = 0;
    int wl, nw;
    asff_formatter asff_formatter_inst (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe_n(oe_n),
        .i_word_length_strap_hi(st_hi), .i_word_length_strap_lo(st_lo), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));
    asff_host asff_host_inst (.i_clock(i_clock), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_din(din));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 50) begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge i_clock);
    endtask
    function automatic logic [31:0] ch(input int k, input int w);
        logic [31:0] r;
        r = 32'h00801234 + 32'(k) * 32'h00101010;
        return (w == 16) ? r >> 8 : r << (w - 24);
    endfunction
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    initial begin
        repeat (90000) @(posedge i_clock);
        mismatches++;
        conclude();
    end
    initial begin
        {i_arst_n, st_hi, st_lo, psel, penable, pwrite, paddr, pwdata} = '0;
        for (int s = 0; s < 3; s++) begin
            wl = (s == 0) ? 24 : (s == 1) ? 32 : 16;
            mon = 16'h5a3c ^ 16'(s);
            @(posedge i_clock);
            i_arst_n <= 1'b0;
            st_hi <= (s == 1);
            st_lo <= (s == 0);
            repeat (20) @(posedge i_clock);
            i_arst_n <= 1'b1;
            repeat (12) @(posedge i_clock);
            apb(0, REG_CONFIG, 0);
            `CHK("config reset", 32'h0, rd)
            apb(0, REG_INFO, 0);
            `CHK("info", {24'h0, 2'b10, 6'(wl)}, rd)
            st_hi <= (s != 1);
            st_lo <= (s == 1);
            apb(1, REG_MONITOR, 32'(mon));
            apb(1, REG_TX_CHECK, 32'hbeef);
            for (int k = 1; k < 5; k++) apb(1, REG_CHAN_BASE + 8'(4 * k - 4), ch(k, 24));
            for (int c = 0; c < 6; c++) begin
                {pw, cr, fx} = cfg[c];
                nw = fx ? 6 : pw ? (cr ? 6 : 5) : (cr ? 2 : 1);
                apb(1, REG_CONFIG, 32'(cfg[c]));
                asff_host_inst.frame(wl, 6, cr ? nw - 1 : -1, 16'h1a00 + 16'(c), 16'hc3c0);
                `CHK("idle enable", 1'b1, oe_n)
                for (int w = 0; w < 6; w++) begin
                    ex = (w == 0) ? 32'(mon) << (wl - 16) : '0;
                    if (cr && w == nw - 1) ex = 32'hbeef << (wl - 16);
                    else if (pw && w > 0 && w < nw && w < 5) ex = ch(w, wl);
                    rd = asff_host_inst.rx[w];
                    `CHK("word", ex, rd)
                end
                apb(0, REG_COMMAND, 0);
                `CHK("command", 32'h1a00 + 32'(c), rd)
                apb(0, REG_RX_CHECK, 0);
                if (cr) `CHK("rx check", 32'hc3c0, rd)
            end
            apb(0, REG_INFO, 0);
            `CHK("info held", {24'h0, 2'b10, 6'(wl)}, rd)
            $display("test word length %0d done", wl);
        end
        apb(1, REG_CONFIG, 0);
        apb(1, REG_IRQ_MASK, 32'h1);
        apb(1, REG_IRQ_STATUS, 32'h7);
        `CHK("irq idle", 1'b0, irq)
        apb(1, REG_RESPONSE, 32'h7e81);
        asff_host_inst.frame(16, 1, -1, 16'h2222, 0);
        `CHK("response", 32'h7e81, asff_host_inst.rx[0])
        `CHK("irq set", 1'b1, irq)
        asff_host_inst.frame(16, 1, -1, 16'h3333, 0);
        `CHK("monitor", 32'(mon), asff_host_inst.rx[0])
        apb(1, REG_IRQ_STATUS, 32'h7);
        `CHK("irq clear", 1'b0, irq)
        apb(1, REG_IRQ_MASK, 32'h0);
        asff_host_inst.frame(16, 1, -1, 16'h4444, 0);
        `CHK("irq masked", 1'b0, irq)
        apb(1, REG_IRQ_MASK, 32'h2);
        `CHK("irq command", 1'b1, irq)
        apb(0, 8'h40, 0);
        `CHK("unmapped", 33'h100000000, {err, rd})
        $display("test status and interrupts done");
        conclude();
    end
endmodule
